// ===== hw/ifsr_pkg.sv
// Constants and field layout for the IF transceiver serial control registers.
//------------------------------------------------------------------------------
// Functional notes
// - Each programming word is 21 bits with 4 address bits and a subaddress.
// - Strobe low shifts data on rising serial clock; strobe high holds contents.
// - Strobe rising transfers payload into the register set chosen by subaddress.
// - Power-up reset loads all control registers with defaults; strobe held low.
// - Subaddress 0 updates divider, pump current and test fields.
// - Main divider is 9-bit binary, 64 to 511 allowed, default 400.
// - Pump current factor 000 minimum to 111 maximum, default 111.
// - The two AGC bits drive the two AGC output pins directly.
// - First offset bit of each channel selects correction polarity.
// - Remaining three offset bits set correction magnitude.
// - IF gain bit 0 no attenuation, 1 inserts 10dB attenuation step.
// - Duty loop mode 00 on, 01 medium tune, 10 off, 11 fine tune.
// - RC filter bit selects 110kHz cutoff when 0, 792kHz when 1.
// - Gyrator bit 1 switches a second resistor in parallel.
// - Regulator enable high powers both regulators.
// - Receiver enable high powers the receive section.
// - Transmit power-down input low powers the transmit section.
// - Synthesizer enable low powers down dividers, resets detector, drops reference.
// - With synthesizer off, registers keep contents and stay writable.
//------------------------------------------------------------------------------
package ifsr_pkg;
  localparam int         WORD_BITS     = 21;
  localparam logic [3:0] CHIP_ADDRESS  = 4'he;
  // Bit positions within the received word, bit 20 arrives first.
  localparam int         ADDR_MSB      = 20;
  localparam int         ADDR_LSB      = 17;
  localparam int         SUBADDR_POS   = 16;
  // First word fields.
  localparam int         DIV_MSB       = 15;
  localparam int         DIV_LSB       = 7;
  localparam int         REF_MSB       = 6;
  localparam int         REF_LSB       = 5;
  localparam int         PUMP_MSB      = 4;
  localparam int         PUMP_LSB      = 2;
  localparam int         TEST_MSB      = 1;
  localparam int         TEST_LSB      = 0;
  // Second word fields.
  localparam int         AGC_MSB       = 15;
  localparam int         AGC_LSB       = 14;
  localparam int         QOFS_MSB      = 13;
  localparam int         QOFS_LSB      = 10;
  localparam int         IOFS_MSB      = 9;
  localparam int         IOFS_LSB      = 6;
  localparam int         MODE_MSB      = 5;
  localparam int         MODE_LSB      = 0;
  // Reset values and the divider minimum.
  localparam logic [8:0] DIV_RESET     = 9'h190;
  localparam logic [1:0] REF_RESET     = 2'h0;
  localparam logic [2:0] PUMP_RESET    = 3'h7;
  localparam logic [1:0] TEST_RESET    = 2'h0;
  localparam logic [1:0] AGC_RESET     = 2'h3;
  localparam logic [7:0] OFS_RESET     = 8'h00;
  localparam logic [5:0] MODE_RESET    = 6'h00;
  localparam logic [8:0] DIV_MIN       = 9'h040;
  // Reference division ratios for each code.
  localparam logic [5:0] REF_RATIO_0   = 6'h0d;
  localparam logic [5:0] REF_RATIO_1   = 6'h1a;
  localparam logic [5:0] REF_RATIO_2   = 6'h27;
  localparam logic [5:0] REF_RATIO_3   = 6'h34;
  typedef enum logic [1:0] {
    IFSR_LOOP_ON, IFSR_LOOP_MEDIUM, IFSR_LOOP_OFF, IFSR_LOOP_FINE
  } ifsr_loop_type;
endpackage : ifsr_pkg

// ===== hw/ifsr_shifter.sv
// Serial shift register that runs on the link clock and latches on strobe.
`timescale 1ns/10ps
module ifsr_shifter
  import ifsr_pkg::*;
(
  input  wire logic                 link_clk,
  input  wire logic                 link_rst,
  input  wire logic                 serial_data,
  input  wire logic                 latch_strobe,
  output logic [WORD_BITS-1:0]      word_q,
  output logic                      word_toggle_q
);
  logic [WORD_BITS-1:0] shift_q;
  logic                 strobe_q;

  // Shifting runs only while the strobe is low; high freezes contents.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      shift_q <= '0;
    end else if (!latch_strobe) begin
      shift_q <= {shift_q[WORD_BITS-2:0], serial_data};
    end
  end

  // A strobe rise needs one more link clock edge to be seen here.
  // The word is captured stable and a toggle tells the core domain.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      strobe_q      <= 1'b0;
      word_q        <= '0;
      word_toggle_q <= 1'b0;
    end else begin
      strobe_q <= latch_strobe;
      if (latch_strobe && !strobe_q) begin
        word_q        <= shift_q;
        word_toggle_q <= ~word_toggle_q;
      end
    end
  end

  a_shift_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    latch_strobe |=> shift_q == $past(shift_q))
    else $error("Shift register moved while strobe high.");
endmodule : ifsr_shifter

// ===== hw/ifsr_regs.sv
// Top of the serial control register bank with its decoded controls.
`timescale 1ns/10ps
module ifsr_regs
  import ifsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       link_clk,
  input  wire logic       serial_data,
  input  wire logic       latch_strobe,
  input  wire logic       regulator_enable,
  input  wire logic       receiver_enable,
  input  wire logic       transmit_power_down_n,
  input  wire logic       synthesizer_enable,
  output logic [8:0]      main_divider_field,
  output logic [1:0]      reference_divider_field,
  output logic [5:0]      reference_ratio,
  output logic [2:0]      pump_current_field,
  output logic [1:0]      test_select_field,
  output logic            agc_bit_a,
  output logic            agc_bit_b,
  output logic            i_offset_polarity,
  output logic [2:0]      i_offset_magnitude,
  output logic            q_offset_polarity,
  output logic [2:0]      q_offset_magnitude,
  output logic            if_attenuation_select,
  output logic            factory_test_bit,
  output logic [1:0]      duty_cycle_loop,
  output logic            duty_loop_running,
  output logic            rc_filter_bandwidth_select,
  output logic            gyrator_resistor_select,
  output logic            divider_range_error,
  output logic            regulators_on,
  output logic            receive_on,
  output logic            transmit_on,
  output logic            synth_dividers_on,
  output logic            phase_detector_reset,
  output logic            current_reference_pin
);
  //----------------------------------------------------------------------------
  // Link side and crossing
  //----------------------------------------------------------------------------
  logic [WORD_BITS-1:0] word_link;
  logic                 toggle_link;
  logic                 link_rst_m_q;
  logic                 link_rst_q;
  logic [2:0]           tog_sync_q;
  logic                 word_accept;
  logic [WORD_BITS-1:0] word;

  // The digital supply reset stands in for sys_rst on the link domain too.
  always_ff @(posedge link_clk) begin
    link_rst_m_q <= sys_rst;
    link_rst_q   <= link_rst_m_q;
  end

  ifsr_shifter u_shifter (
    .link_clk      (link_clk),
    .link_rst      (link_rst_q),
    .serial_data   (serial_data),
    .latch_strobe  (latch_strobe),
    .word_q        (word_link),
    .word_toggle_q (toggle_link)
  );

  // The toggle passes two flops; the word is stable long before it is read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tog_sync_q <= 3'h0;
    end else if (clk_en) begin
      tog_sync_q <= {tog_sync_q[1:0], toggle_link};
    end
  end

  assign word        = word_link;
  assign word_accept = clk_en && (tog_sync_q[2] != tog_sync_q[1]) &&
                       (word[ADDR_MSB:ADDR_LSB] == CHIP_ADDRESS);

  //----------------------------------------------------------------------------
  // Working registers
  //----------------------------------------------------------------------------
  function automatic logic [5:0] ref_ratio(input logic [1:0] code);
    case (code)
      2'h0:    ref_ratio = REF_RATIO_0;
      2'h1:    ref_ratio = REF_RATIO_1;
      2'h2:    ref_ratio = REF_RATIO_2;
      default: ref_ratio = REF_RATIO_3;
    endcase
  endfunction : ref_ratio

  // First word: subaddress 0 loads synthesizer fields, kept with PLL off.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_divider_field      <= DIV_RESET;
      reference_divider_field <= REF_RESET;
      reference_ratio         <= REF_RATIO_0;
      pump_current_field      <= PUMP_RESET;
      test_select_field       <= TEST_RESET;
      divider_range_error     <= 1'b0;
    end else if (word_accept && !word[SUBADDR_POS]) begin
      main_divider_field      <= word[DIV_MSB:DIV_LSB];
      reference_divider_field <= word[REF_MSB:REF_LSB];
      reference_ratio         <= ref_ratio(word[REF_MSB:REF_LSB]);
      // The pump factor's least significant bit is sent first in the word.
      pump_current_field      <= {word[PUMP_LSB], word[PUMP_LSB+1],
                                  word[PUMP_MSB]};
      test_select_field       <= word[TEST_MSB:TEST_LSB];
      divider_range_error     <= word[DIV_MSB:DIV_LSB] < DIV_MIN;
    end
  end

  // Second word: subaddress 1 loads AGC, offsets and mode bits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {agc_bit_a, agc_bit_b}       <= AGC_RESET;
      {q_offset_polarity, q_offset_magnitude,
       i_offset_polarity, i_offset_magnitude} <= OFS_RESET;
      {if_attenuation_select, factory_test_bit, duty_cycle_loop,
       rc_filter_bandwidth_select, gyrator_resistor_select} <= MODE_RESET;
      duty_loop_running            <= 1'b1;
    end else if (word_accept && word[SUBADDR_POS]) begin
      {agc_bit_a, agc_bit_b}  <= word[AGC_MSB:AGC_LSB];
      q_offset_polarity       <= word[QOFS_MSB];
      q_offset_magnitude      <= word[QOFS_MSB-1:QOFS_LSB];
      i_offset_polarity       <= word[IOFS_MSB];
      i_offset_magnitude      <= word[IOFS_MSB-1:IOFS_LSB];
      if_attenuation_select   <= word[MODE_MSB];
      factory_test_bit        <= word[MODE_MSB-1]; // is the caller's
      duty_cycle_loop         <= word[MODE_MSB-2:MODE_MSB-3];
      duty_loop_running       <= ifsr_loop_type'(word[MODE_MSB-2:MODE_MSB-3])
                                 != IFSR_LOOP_OFF;
      rc_filter_bandwidth_select <= word[MODE_LSB+1];
      gyrator_resistor_select <= word[MODE_LSB];
    end
  end

  //----------------------------------------------------------------------------
  // Power control
  //----------------------------------------------------------------------------
  logic [1:0] reg_s_q, rx_s_q, tx_s_q, syn_s_q;

  // Pin levels are asynchronous, so each passes two flops first.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_s_q <= 2'h0;
      rx_s_q  <= 2'h0;
      tx_s_q  <= 2'h3;
      syn_s_q <= 2'h0;
    end else if (clk_en) begin
      reg_s_q <= {reg_s_q[0], regulator_enable};
      rx_s_q  <= {rx_s_q[0], receiver_enable};
      tx_s_q  <= {tx_s_q[0], transmit_power_down_n};
      syn_s_q <= {syn_s_q[0], synthesizer_enable}; // is the caller's
    end
  end

  // Power states follow the synchronised pins; registers are untouched.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regulators_on         <= 1'b0;
      receive_on            <= 1'b0;
      transmit_on           <= 1'b0;
      synth_dividers_on     <= 1'b0;
      phase_detector_reset  <= 1'b1;
      current_reference_pin <= 1'b0;
    end else if (clk_en) begin
      regulators_on         <= reg_s_q[1];
      receive_on            <= rx_s_q[1];
      transmit_on           <= !tx_s_q[1];
      synth_dividers_on     <= syn_s_q[1];
      phase_detector_reset  <= !syn_s_q[1];
      current_reference_pin <= syn_s_q[1];
    end
  end

  a_agc_load: assert property (@(posedge clk) disable iff (sys_rst)
    word_accept && word[SUBADDR_POS] |=>
      {agc_bit_a, agc_bit_b} == $past(word[AGC_MSB:AGC_LSB]))
    else $error("AGC pins did not follow word.");
  a_div_load: assert property (@(posedge clk) disable iff (sys_rst)
    word_accept && !word[SUBADDR_POS] |=>
      main_divider_field == $past(word[DIV_MSB:DIV_LSB]))
    else $error("Divider not loaded by first word.");
  a_foreign_addr: assert property (@(posedge clk) disable iff (sys_rst)
    word[ADDR_MSB:ADDR_LSB] != CHIP_ADDRESS |=>
      $stable(main_divider_field) && $stable(agc_bit_a))
    else $error("Foreign address changed registers.");
  a_ref_ratio: assert property (@(posedge clk) disable iff (sys_rst)
    reference_divider_field == 2'h3 |-> reference_ratio == 6'h34)
    else $error("Reference ratio mismatch.");
  a_synth_off: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !syn_s_q[1] |=> phase_detector_reset && !current_reference_pin)
    else $error("Synthesizer off not applied.");
  a_tx_power: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !tx_s_q[1] |=> transmit_on)
    else $error("Transmit not powered on low input.");
  a_pump_load: assert property (@(posedge clk) disable iff (sys_rst)
    word_accept && !word[SUBADDR_POS] |=>
      pump_current_field == $past({word[PUMP_LSB], word[PUMP_LSB+1],
                                   word[PUMP_MSB]}))
    else $error("Pump current not loaded.");
  a_offset_load: assert property (@(posedge clk) disable iff (sys_rst)
    word_accept && word[SUBADDR_POS] |=>
      i_offset_polarity == $past(word[IOFS_MSB]))
    else $error("I offset polarity not loaded.");
endmodule : ifsr_regs

// ===== dv/ifsr_ctrl_model.sv
// Baseband controller model that drives the three-wire serial port.
`timescale 1ns/10ps
module ifsr_ctrl_model (
  output logic link_clk,
  output logic serial_data,
  output logic latch_strobe
);
  // The link clock rests low between frames, and the strobe starts low.
  initial begin
    link_clk     = 1'b0;
    serial_data  = 1'b0;
    latch_strobe = 1'b0;
  end
  // Bare pulses with the strobe low, so that the link side sees its reset.
  task automatic pulse(input int n);
    latch_strobe = 1'b0;
    repeat (n) begin
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
  endtask : pulse
  // Shifts nb bits, MSB first, then latches them with one more rising edge.
  // A gap stretches the low phase, as a slow controller would.
  task automatic send_word(input logic [31:0] w, input int nb,
                           input int gap);
    latch_strobe = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      serial_data = w[i];
      #(80 + gap) link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    // The bit is not held past its hold time, so drive its inverse.
    serial_data  = ~serial_data;
    latch_strobe = 1'b1;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask : send_word
endmodule : ifsr_ctrl_model

// ===== dv/ifsr_regs_tb.sv
// Self-checking bench for the serial control register bank.
`timescale 1ns/10ps
module ifsr_regs_tb;
  import ifsr_pkg::*;
  logic        clk, sys_rst, clk_en, link_clk, serial_data, latch_strobe;
  logic        regulator_enable, receiver_enable, transmit_power_down_n;
  logic        synthesizer_enable, agc_bit_a, agc_bit_b, factory_test_bit;
  logic        i_offset_polarity, q_offset_polarity, if_attenuation_select;
  logic        duty_loop_running, rc_filter_bandwidth_select;
  logic        gyrator_resistor_select, divider_range_error, regulators_on;
  logic        receive_on, transmit_on, synth_dividers_on;
  logic        phase_detector_reset, current_reference_pin;
  logic [8:0]  main_divider_field;
  logic [5:0]  reference_ratio;
  logic [2:0]  pump_current_field, i_offset_magnitude, q_offset_magnitude;
  logic [1:0]  reference_divider_field, test_select_field, duty_cycle_loop;
  logic [20:0] w0, w1;
  logic [31:0] seed;
  int          n_mismatch, cmp_count;
  ifsr_regs ifsr_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .link_clk(link_clk),
    .serial_data(serial_data), .latch_strobe(latch_strobe),
    .regulator_enable(regulator_enable), .receiver_enable(receiver_enable),
    .transmit_power_down_n(transmit_power_down_n),
    .synthesizer_enable(synthesizer_enable),
    .main_divider_field(main_divider_field),
    .reference_divider_field(reference_divider_field),
    .reference_ratio(reference_ratio),
    .pump_current_field(pump_current_field),
    .test_select_field(test_select_field),
    .agc_bit_a(agc_bit_a), .agc_bit_b(agc_bit_b),
    .i_offset_polarity(i_offset_polarity),
    .i_offset_magnitude(i_offset_magnitude),
    .q_offset_polarity(q_offset_polarity),
    .q_offset_magnitude(q_offset_magnitude),
    .if_attenuation_select(if_attenuation_select),
    .factory_test_bit(factory_test_bit),
    .duty_cycle_loop(duty_cycle_loop),
    .duty_loop_running(duty_loop_running),
    .rc_filter_bandwidth_select(rc_filter_bandwidth_select),
    .gyrator_resistor_select(gyrator_resistor_select),
    .divider_range_error(divider_range_error),
    .regulators_on(regulators_on), .receive_on(receive_on),
    .transmit_on(transmit_on), .synth_dividers_on(synth_dividers_on),
    .phase_detector_reset(phase_detector_reset),
    .current_reference_pin(current_reference_pin)
  );
  ifsr_ctrl_model ifsr_ctrl_model_inst (
    .link_clk(link_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe)
  );
  // Core clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far beyond the longest expected run.
  initial begin
    #3000000;
    n_mismatch++;
    report_and_stop;
  end
  // ------
  // Checks
  // ------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Ratio is 13 times the sum of the code and one.
  function automatic logic [5:0] ratio_of(input logic [1:0] c);
    return 6'h0d * ({4'h0, c} + 6'h01);
  endfunction : ratio_of
  // Compares every field against the last accepted word of each kind.
  task automatic check_regs;
    chk("div", w0[15:7], main_divider_field);
    chk("ref", w0[6:5], reference_divider_field);
    chk("ratio", ratio_of(w0[6:5]), reference_ratio);
    chk("pump", {w0[2], w0[3], w0[4]}, pump_current_field);
    chk("test", w0[1:0], test_select_field);
    chk("range", w0[15:7] < 9'h040, divider_range_error);
    chk("agc_a", w1[15], agc_bit_a);
    chk("agc_b", w1[14], agc_bit_b);
    chk("q_pol", w1[13], q_offset_polarity);
    chk("q_mag", w1[12:10], q_offset_magnitude);
    chk("i_pol", w1[9], i_offset_polarity);
    chk("i_mag", w1[8:6], i_offset_magnitude);
    chk("atten", w1[5], if_attenuation_select);
    chk("factory", w1[4], factory_test_bit);
    chk("loop", w1[3:2], duty_cycle_loop);
    chk("loop_run", w1[3:2] != 2'h2, duty_loop_running);
    chk("rc_bw", w1[1], rc_filter_bandwidth_select);
    chk("gyr", w1[0], gyrator_resistor_select);
  endtask : check_regs
  task automatic check_power;
    chk("reg_on", regulator_enable, regulators_on);
    chk("rx_on", receiver_enable, receive_on);
    chk("tx_on", !transmit_power_down_n, transmit_on);
    chk("synth", synthesizer_enable, synth_dividers_on);
    chk("pd_rst", !synthesizer_enable, phase_detector_reset);
    chk("current_reference_pin", synthesizer_enable, current_reference_pin);
  endtask : check_power
  // Link pulses run inside reset so the link side is reset as well.
  task automatic do_reset;
    @(posedge clk);
    #1 sys_rst = 1'b1;
    fork
      ifsr_ctrl_model_inst.pulse(4);
    join_none
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    ifsr_ctrl_model_inst.pulse(3);
    w0 = {4'he, 1'b0, 9'h190, 2'h0, 3'h7, 2'h0};
    w1 = {4'he, 1'b1, 2'h3, 8'h00, 6'h00};
    repeat (2) @(posedge clk);
    #1 check_regs;
  endtask : do_reset
  // Sends one word, keeps the expectation, and checks once it has crossed.
  task automatic send(input logic [31:0] w, input int nb, input int gap);
    ifsr_ctrl_model_inst.send_word(w, nb, gap);
    if (w[20:17] == 4'he) begin
      if (w[16]) w1 = w[20:0];
      else w0 = w[20:0];
    end
    repeat (6) @(posedge clk);
    #1 check_regs;
  endtask : send
  // --------
  // Stimulus
  // --------
  initial begin
    logic [31:0] r, w;
    logic [8:0]  divs [4];
    seed = 32'h010a48ac;
    n_mismatch = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    regulator_enable = 1'b0;
    receiver_enable = 1'b0;
    transmit_power_down_n = 1'b1;
    synthesizer_enable = 1'b0;
    divs = '{9'h040, 9'h1ff, 9'h03f, 9'h0c8};
    do_reset;
    check_power;
    // Divider bounds, each reference code, loop mode and polarity.
    for (int i = 0; i < 4; i++) begin
      send({11'h0, 4'he, 1'b0, divs[i], i[1:0], i[2:0], i[1:0]},
           21, 0);
      send({11'h0, 4'he, 1'b1, i[1:0], i[3:0], ~i[3:0], i[1], 1'b0,
            i[1:0], i[0], ~i[0]}, 21, 0);
    end
    send({11'h0, 4'h7, 1'b1, 16'hffef}, 21, 0);
    // Random words, lengths, gaps, addresses and power pins.
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      w = $random(seed);
      @(posedge clk);
      #1;
      regulator_enable = r[0];
      receiver_enable = r[1];
      transmit_power_down_n = r[2];
      synthesizer_enable = r[3] | r[1] | ~r[2];
      w[20:17] = (r[6:4] == 3'h0) ? r[10:7] : 4'he;
      if (w[16]) w[4] = 1'b0;
      send(w, 21 + int'(r[12:11]), 100 * int'(r[14:13]));
      check_power;
    end
    do_reset;
    report_and_stop;
  end
endmodule : ifsr_regs_tb
